// ---- src/rlf_consts.svh ----
`ifndef RLF_CONSTS_SVH
`define RLF_CONSTS_SVH
// register numbering
`define RLF_RSSI_BASE 16'h1131
`define RLF_RSSI_COUNT 95
`define RLF_STATUS_OFFSET 16'h1388
`define RLF_NUM_POINTS 64
`define RLF_POINT_W 6
// address ranges
`define RLF_MAX_DIRECT 7'h5F
`define RLF_SUB_FIRST 7'h60
`define RLF_MAX_HOPS 5
// retries and timing
`define RLF_TX_ATTEMPTS 3'h5
`define RLF_TICK_NS 1000000
`define RLF_CLK_NS 8
`define RLF_TICK_CYC (`RLF_TICK_NS / `RLF_CLK_NS)
// field positions
`define RLF_FAIL_BIT 15
`endif

// ---- src/rlf_pkg.sv ----
package rlf_pkg;
    typedef logic [6:0] rlf_addr_t;
    typedef logic [7:0] rlf_rssi_t;
    typedef logic [15:0] rlf_word_t;
    typedef logic [15:0] rlf_tmo_t;
    typedef enum logic [1:0] {
        RLF_IDLE,
        RLF_WAIT_ACK,
        RLF_DONE
    } rlf_tx_state_t;
    typedef struct packed {
        logic is_output;
        rlf_addr_t addr;
        rlf_addr_t parent;
        rlf_tmo_t timeout;
    } rlf_point_cfg_t;
endpackage : rlf_pkg

// ---- src/rlf_tick_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface rlf_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface : rlf_tick_if
`default_nettype wire

// ---- src/rlf_tick_gen.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "rlf_consts.svh"
module rlf_tick_gen #(
    parameter int unsigned TICK_CYC = `RLF_TICK_CYC
) (
    input wire logic mclk,
    input wire logic rstn,
    rlf_tick_if.src tk
);
    logic [16:0] cnt;
    logic [16:0] next_cnt;
    logic next_tick;
    logic tick_q;

    always_comb begin
        next_tick = (cnt == 17'(TICK_CYC - 1));
        next_cnt = next_tick ? 17'h0_0000 : cnt + 17'h0_0001;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 17'h0_0000;
            tick_q <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick_q <= next_tick;
        end
    end

    assign tk.tick = tick_q;

    tick_period_a: assert property (@(posedge mclk) disable iff (!rstn)
        tick_q |=> !tick_q[*2])
        else $error("tick repeated too soon");
endmodule : rlf_tick_gen
`default_nettype wire

// ---- src/rlf_tracker.sv ----
// Operation
// RULE1 - remote addresses 1 to 95 each have status and strength entries
// RULE2 - sub-modules 96 to 127 are told apart by their parent address
// RULE3 - strength register for address n sits at base plus n-1
// RULE4 - strength kept as unsigned dBm magnitude in low byte
// RULE5 - each message overwrites strength of sender or last repeater
// RULE6 - upper byte zero when healthy, top bit set in comms fail
// RULE7 - routes with up to five repeaters are accepted
// RULE8 - output fail set on missing ack, cleared on acked transmission
// RULE9 - input fail set on timeout expiry, cleared on message arrival
// RULE10 - zero timeout never sets the input fail flag
// RULE11 - point fail flag is bit 15 of its status register
// RULE12 - single-bit read returns bit 15 of the addressed register
// RULE13 - per-address suppression enable; output fail sets address fail
// RULE14 - address fail cleared when an input of that address receives
// RULE15 - address fail withholds outputs and marks them failed
// RULE16 - status register number is value register plus 5000
// RULE17 - five attempts are made before an output is declared failed
// RULE18 - suppression disabled for all addresses after reset
// RULE19 - input timeout restarts on message, counts fixed ticks
`timescale 1ns/100ps
`default_nettype none
`include "rlf_consts.svh"
module rlf_tracker #(
    parameter int unsigned TICK_CYC = `RLF_TICK_CYC
) (
    input wire logic mclk,
    input wire logic rstn,
    // configuration of each point
    input wire logic cfg_we,
    input wire logic [5:0] cfg_point,
    input wire rlf_pkg::rlf_point_cfg_t cfg_data,
    input wire logic supp_we,
    input wire rlf_pkg::rlf_addr_t supp_addr,
    input wire logic supp_en,
    // received message from radio engine
    input wire logic rx_valid,
    input wire rlf_pkg::rlf_addr_t rx_src,
    input wire rlf_pkg::rlf_addr_t rx_parent,
    input wire logic [2:0] rx_hops,
    input wire rlf_pkg::rlf_addr_t rx_last_rpt,
    input wire rlf_pkg::rlf_rssi_t rx_rssi,
    // transmit request and acknowledge outcome
    input wire logic tx_req,
    input wire logic [5:0] tx_point,
    output logic tx_go,
    output logic tx_withheld,
    input wire logic tx_ack,
    input wire logic tx_noack,
    // host register read
    input wire logic rd_en,
    input wire logic rd_bit,
    input wire rlf_pkg::rlf_word_t rd_reg,
    output rlf_pkg::rlf_word_t rd_data,
    output logic rd_valid,
    output logic rd_hit
);
    localparam int NP = `RLF_NUM_POINTS;

    rlf_tick_if tki ();
    rlf_tick_gen #(.TICK_CYC(TICK_CYC)) u_tick (
        .mclk(mclk),
        .rstn(rstn),
        .tk(tki)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    rlf_pkg::rlf_point_cfg_t cfg [NP];
    rlf_pkg::rlf_tmo_t tmo [NP];
    logic [NP-1:0] pfail;
    logic [95:0] supp;
    logic [95:0] afail;
    rlf_pkg::rlf_rssi_t rssi [96];
    rlf_pkg::rlf_tx_state_t st;
    logic [5:0] cur;
    logic [2:0] tries;

    logic [NP-1:0] next_pfail;
    logic [95:0] next_afail;
    logic [95:0] next_supp;
    rlf_pkg::rlf_tmo_t next_tmo [NP];
    rlf_pkg::rlf_tx_state_t next_st;
    logic [5:0] next_cur;
    logic [2:0] next_tries;
    logic out_fail_set;
    logic out_ok;
    logic rx_ok;
    rlf_pkg::rlf_addr_t rssi_addr;

    // ------------------------------------------------------------
    // receive classification
    // ------------------------------------------------------------
    always_comb begin
        rx_ok = rx_valid && rx_src != 7'h00
            && rx_hops <= 3'(`RLF_MAX_HOPS); // see RULE7
        rssi_addr = (rx_hops != 3'h0) ? rx_last_rpt : rx_src; // see RULE5
    end

    // ------------------------------------------------------------
    // transmit sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_cur = cur;
        next_tries = tries;
        tx_go = 1'b0;
        tx_withheld = 1'b0;
        out_fail_set = 1'b0;
        out_ok = 1'b0;
        case (st)
            rlf_pkg::RLF_IDLE: begin
                if (tx_req && cfg[tx_point].is_output) begin
                    next_cur = tx_point;
                    if (cfg[tx_point].addr <= `RLF_MAX_DIRECT
                        && afail[cfg[tx_point].addr]) begin
                        tx_withheld = 1'b1; // see RULE15
                    end else begin
                        tx_go = 1'b1;
                        next_tries = 3'h1;
                        next_st = rlf_pkg::RLF_WAIT_ACK;
                    end
                end
            end
            rlf_pkg::RLF_WAIT_ACK: begin
                if (tx_ack) begin
                    out_ok = 1'b1;
                    next_st = rlf_pkg::RLF_DONE;
                end else if (tx_noack) begin
                    if (tries == `RLF_TX_ATTEMPTS) begin // see RULE17
                        out_fail_set = 1'b1; // see RULE8
                        next_st = rlf_pkg::RLF_DONE;
                    end else begin
                        tx_go = 1'b1;
                        next_tries = tries + 3'h1;
                    end
                end
            end
            rlf_pkg::RLF_DONE: next_st = rlf_pkg::RLF_IDLE;
            default: next_st = rlf_pkg::RLF_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // fail flags and timeouts
    // ------------------------------------------------------------
    always_comb begin
        next_pfail = pfail;
        next_afail = afail;
        next_supp = supp;
        for (int i = 0; i < NP; i++) begin
            next_tmo[i] = tmo[i];
            if (!cfg[i].is_output) begin
                // sub-module match needs parent too
                if (rx_ok && rx_src == cfg[i].addr
                    && (rx_src < `RLF_SUB_FIRST
                        || rx_parent == cfg[i].parent)) begin // see RULE2
                    next_tmo[i] = cfg[i].timeout; // see RULE19
                    next_pfail[i] = 1'b0; // see RULE9
                    if (cfg[i].addr <= `RLF_MAX_DIRECT) begin
                        next_afail[cfg[i].addr] = 1'b0; // see RULE14
                    end
                end else if (tki.tick && cfg[i].timeout != 16'h0000
                    && tmo[i] != 16'h0000) begin // see RULE10
                    next_tmo[i] = tmo[i] - 16'h0001;
                    if (tmo[i] == 16'h0001) begin
                        next_pfail[i] = 1'b1; // see RULE9
                    end
                end
            end
        end
        // clear only on an acknowledged attempt, not on the done cycle
        if (out_ok) begin
            next_pfail[cur] = 1'b0; // see RULE8
        end
        if (out_fail_set || tx_withheld) begin
            next_pfail[next_cur] = 1'b1; // see RULE15
            if (cfg[next_cur].addr <= `RLF_MAX_DIRECT
                && supp[cfg[next_cur].addr]) begin
                next_afail[cfg[next_cur].addr] = 1'b1; // see RULE13
            end
        end
        if (supp_we && supp_addr <= `RLF_MAX_DIRECT) begin
            next_supp[supp_addr] = supp_en; // see RULE13
            if (!supp_en) begin
                next_afail[supp_addr] = 1'b0;
            end
        end
        next_afail[0] = 1'b0;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st <= rlf_pkg::RLF_IDLE;
            cur <= 6'h00;
            tries <= 3'h0;
            pfail <= '0;
            afail <= '0;
            supp <= '0; // see RULE18
            for (int i = 0; i < NP; i++) begin
                tmo[i] <= 16'h0000;
                cfg[i] <= '0;
            end
            for (int a = 0; a < 96; a++) begin
                rssi[a] <= 8'h00;
            end
        end else begin
            st <= next_st;
            cur <= next_cur;
            tries <= next_tries;
            pfail <= next_pfail;
            afail <= next_afail;
            supp <= next_supp;
            for (int i = 0; i < NP; i++) begin
                tmo[i] <= next_tmo[i];
            end
            if (cfg_we) begin
                cfg[cfg_point] <= cfg_data;
            end
            if (rx_ok && rssi_addr <= `RLF_MAX_DIRECT) begin
                rssi[rssi_addr] <= rx_rssi; // see RULE1
            end
        end
    end

    // ------------------------------------------------------------
    // host read port
    // ------------------------------------------------------------
    rlf_pkg::rlf_word_t rword;
    logic rhit;
    logic [15:0] ridx;
    always_comb begin
        rword = 16'h0000;
        rhit = 1'b0;
        ridx = rd_reg - `RLF_RSSI_BASE;
        if (rd_reg >= `RLF_RSSI_BASE
            && ridx < 16'(`RLF_RSSI_COUNT)) begin // see RULE3
            rhit = 1'b1;
            // see RULE4 see RULE6
            rword = {afail[ridx[6:0] + 7'h01], 7'h00,
                rssi[ridx[6:0] + 7'h01]};
        end else if (rd_reg >= `RLF_STATUS_OFFSET
            && rd_reg < `RLF_STATUS_OFFSET + 16'(NP)) begin // see RULE16
            rhit = 1'b1;
            ridx = rd_reg - `RLF_STATUS_OFFSET;
            rword = {pfail[ridx[5:0]], 15'h0000}; // see RULE11
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rd_data <= 16'h0000;
            rd_valid <= 1'b0;
            rd_hit <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            rd_hit <= rd_en && rhit;
            if (rd_en) begin
                rd_data <= rd_bit ? {15'h0000, rword[`RLF_FAIL_BIT]}
                    : rword; // see RULE12
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    withhold_marks_a: assert property (@(posedge mclk) disable iff (!rstn)
        tx_withheld |=> pfail[$past(next_cur)]) // see RULE15
        else $error("withheld output not marked failed");
    fifth_try_a: assert property (@(posedge mclk) disable iff (!rstn)
        out_fail_set |-> tries == 3'h5) // see RULE17
        else $error("fail declared before five attempts");
    fail_kept_a: assert property (@(posedge mclk) disable iff (!rstn)
        out_fail_set |-> ##2 pfail[$past(cur, 2)]) // see RULE8
        else $error("output fail flag lost after last attempt");
    bit_read_a: assert property (@(posedge mclk) disable iff (!rstn)
        rd_en && rd_bit |=> rd_data[15:1] == 15'h0000) // see RULE12
        else $error("bit read wider than one bit");
    rssi_upper_a: assert property (@(posedge mclk) disable iff (!rstn)
        rd_en && !rd_bit && rhit && rd_reg < `RLF_STATUS_OFFSET
        |=> rd_data[14:8] == 7'h00) // see RULE6
        else $error("strength upper byte not clear");
    no_go_fail_a: assert property (@(posedge mclk) disable iff (!rstn)
        tx_go |-> !tx_withheld) // see RULE15
        else $error("go and withhold together");
    supp_reset_a: assert property (@(posedge mclk)
        $rose(rstn) |-> supp == 96'h0) // see RULE18
        else $error("suppression enabled at reset");
endmodule : rlf_tracker
`default_nettype wire

// ---- verif/rlf_radio_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// radio engine acknowledge side
// ----------------------------------------
module rlf_radio_model (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic tx_go,
    input wire logic nack_all,
    input wire logic [2:0] lag,
    output logic tx_ack,
    output logic tx_noack,
    output int n_go
);
    logic pend;
    logic [2:0] wait_c;
    // one outcome per attempt, after lag cycles of silence
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pend <= 1'b0;
            wait_c <= 3'h0;
            n_go <= 0;
        end else if (tx_go) begin
            pend <= 1'b1;
            wait_c <= lag;
            n_go <= n_go + 1;
        end else if (pend && wait_c != 3'h0) begin
            wait_c <= wait_c - 3'h1;
        end else begin
            pend <= 1'b0;
        end
    end
    always @(negedge mclk) begin
        tx_ack <= pend && wait_c == 3'h0 && !nack_all;
        tx_noack <= pend && wait_c == 3'h0 && nack_all;
    end
endmodule : rlf_radio_model
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "rlf_consts.svh"
module testbench;
    logic mclk, rstn, cfg_we, supp_we, supp_en, rx_valid, tx_req, rd_en;
    logic rd_bit, tx_ack, tx_noack, tx_go, tx_withheld, rd_valid, rd_hit;
    logic nack_all;
    logic [5:0] cfg_point, tx_point;
    logic [2:0] rx_hops, lag;
    rlf_pkg::rlf_point_cfg_t cfg_data;
    rlf_pkg::rlf_addr_t supp_addr, rx_src, rx_parent, rx_last_rpt, a;
    rlf_pkg::rlf_rssi_t rx_rssi, r, r5;
    rlf_pkg::rlf_word_t rd_reg, rd_data;
    int n_go, bad_count, n_tests, cyc, g0;

    rlf_tracker #(.TICK_CYC(4)) dut_u (.mclk(mclk), .rstn(rstn),
        .cfg_we(cfg_we), .cfg_point(cfg_point), .cfg_data(cfg_data),
        .supp_we(supp_we), .supp_addr(supp_addr), .supp_en(supp_en),
        .rx_valid(rx_valid), .rx_src(rx_src), .rx_parent(rx_parent),
        .rx_hops(rx_hops), .rx_last_rpt(rx_last_rpt), .rx_rssi(rx_rssi),
        .tx_req(tx_req), .tx_point(tx_point), .tx_go(tx_go),
        .tx_withheld(tx_withheld), .tx_ack(tx_ack), .tx_noack(tx_noack),
        .rd_en(rd_en), .rd_bit(rd_bit), .rd_reg(rd_reg),
        .rd_data(rd_data), .rd_valid(rd_valid), .rd_hit(rd_hit));
    rlf_radio_model partner_u (.mclk(mclk), .rstn(rstn), .tx_go(tx_go),
        .nack_all(nack_all), .lag(lag), .tx_ack(tx_ack),
        .tx_noack(tx_noack), .n_go(n_go));

    // ----------------------------------------
    // expectations and bus tasks
    // ----------------------------------------
    function automatic logic [15:0] sreg(input int n);
        return `RLF_RSSI_BASE + 16'(n - 1);
    endfunction : sreg
    function automatic logic [15:0] stat(input int p);
        return `RLF_STATUS_OFFSET + 16'(p);
    endfunction : stat
    task automatic end_sim();
        if (bad_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [15:0] e, g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rd(input logic [15:0] rg, input logic b,
                      input logic [15:0] e, input logic h);
        rd_en = 1'b1;
        rd_reg = rg;
        rd_bit = b;
        @(negedge mclk);
        rd_en = 1'b0;
        chk("rd_data", e, rd_data);
        chk("rd_hit", {15'h0000, h}, {15'h0000, rd_hit});
        chk("rd_valid", 16'h0001, {15'h0000, rd_valid});
        @(negedge mclk);
    endtask : rd
    task automatic rx(input rlf_pkg::rlf_addr_t s, p, input logic [2:0] h,
                      input rlf_pkg::rlf_addr_t l,
                      input rlf_pkg::rlf_rssi_t v);
        rx_src = s;
        rx_parent = p;
        rx_hops = h;
        rx_last_rpt = l;
        rx_rssi = v;
        rx_valid = 1'b1;
        @(negedge mclk);
        rx_valid = 1'b0;
        @(negedge mclk);
    endtask : rx
    task automatic cfg(input logic [5:0] pt, input rlf_pkg::rlf_point_cfg_t d);
        cfg_point = pt;
        cfg_data = d;
        cfg_we = 1'b1;
        @(negedge mclk);
        cfg_we = 1'b0;
        @(negedge mclk);
    endtask : cfg
    // one output request; attempts counted by the radio model
    task automatic tx(input logic nk, input logic [15:0] e_go,
                      input logic e_wh);
        nack_all = nk;
        lag = 3'($urandom % 4);
        g0 = n_go;
        tx_point = 6'h01;
        tx_req = 1'b1;
        #1;
        chk("tx_withheld", {15'h0000, e_wh}, {15'h0000, tx_withheld});
        @(negedge mclk);
        tx_req = 1'b0;
        repeat (40) @(negedge mclk);
        chk("attempts", e_go, 16'(n_go - g0));
    endtask : tx

    // ----------------------------------------
    // clock, watchdog, sequence
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc > 3000) begin
            bad_count++;
            end_sim();
        end
    end
    initial begin
        {cfg_we, supp_we, supp_en, rx_valid, tx_req, rd_en, rd_bit} = '0;
        {cfg_point, tx_point, rx_hops, lag, nack_all} = '0;
        {cfg_data, supp_addr, rx_src, rx_parent, rx_last_rpt} = '0;
        {rx_rssi, rd_reg} = '0;
        rstn = 1'b0;
        void'($urandom(32'h61220854));
        repeat (8) @(negedge mclk);
        rstn = 1'b1;
        @(negedge mclk);
        rd(sreg(1), 1'b0, 16'h0000, 1'b1);
        rd(sreg(95), 1'b0, 16'h0000, 1'b1);
        rd(sreg(96), 1'b0, 16'h0000, 1'b0);
        rd(`RLF_RSSI_BASE - 16'h0001, 1'b0, 16'h0000, 1'b0);
        cfg(6'h00, {1'b0, 7'h64, 7'h10, 16'h0003});
        cfg(6'h03, {1'b0, 7'h64, 7'h41, 16'h0003});
        cfg(6'h02, {1'b0, 7'h05, 7'h00, 16'h0000});
        cfg(6'h01, {1'b1, 7'h05, 7'h00, 16'h0000});
        for (int i = 0; i < 6; i++) begin
            a = 7'(1 + $urandom % 95);
            r = 8'($urandom);
            rx(a, 7'h00, 3'h0, 7'h00, r);
            rd(sreg(a), 1'b0, {8'h00, r}, 1'b1);
        end
        rx(7'h09, 7'h00, 3'h5, 7'h08, 8'h4a);
        rd(sreg(8), 1'b0, 16'h004a, 1'b1);
        rx(7'h09, 7'h00, 3'h6, 7'h08, 8'h21);
        rd(sreg(8), 1'b0, 16'h004a, 1'b1);
        r5 = 8'($urandom);
        rx(7'h05, 7'h00, 3'h0, 7'h00, r5);
        rx(7'h64, 7'h10, 3'h0, 7'h00, 8'h30);
        rx(7'h64, 7'h41, 3'h0, 7'h00, 8'h30);
        repeat (40) @(negedge mclk);
        rd(stat(0), 1'b0, 16'h8000, 1'b1);
        rd(stat(3), 1'b0, 16'h8000, 1'b1);
        rd(stat(2), 1'b0, 16'h0000, 1'b1);
        repeat (5) begin
            rx(7'h64, 7'h10, 3'h0, 7'h00, 8'h30);
            repeat (6) @(negedge mclk);
        end
        rd(stat(0), 1'b0, 16'h0000, 1'b1);
        rd(stat(3), 1'b0, 16'h8000, 1'b1);
        rd(stat(3), 1'b1, 16'h0001, 1'b1);
        tx(1'b1, 16'h0005, 1'b0);
        rd(stat(1), 1'b0, 16'h8000, 1'b1);
        rd(sreg(5), 1'b0, {8'h00, r5}, 1'b1);
        tx(1'b0, 16'h0001, 1'b0);
        rd(stat(1), 1'b0, 16'h0000, 1'b1);
        supp_addr = 7'h05;
        supp_en = 1'b1;
        supp_we = 1'b1;
        @(negedge mclk);
        supp_we = 1'b0;
        @(negedge mclk);
        tx(1'b1, 16'h0005, 1'b0);
        rd(sreg(5), 1'b0, {8'h80, r5}, 1'b1);
        tx(1'b0, 16'h0000, 1'b1);
        rd(stat(1), 1'b0, 16'h8000, 1'b1);
        r5 = 8'($urandom);
        rx(7'h05, 7'h00, 3'h0, 7'h00, r5);
        rd(sreg(5), 1'b0, {8'h00, r5}, 1'b1);
        tx(1'b0, 16'h0001, 1'b0);
        end_sim();
    end
endmodule : testbench
`default_nettype wire
